// ### fplc_csr_bank.v
// float status, hardware loop and identity csr bank
`include "fplc_consts.vh"

module fplc_csr_bank #(
    parameter float_unit_present = 1,
    parameter custom_extension_enable = 1
) (
    // clock and reset
    input wire mclk,
    input wire srst,
    // csr access from the pipeline
    input wire csr_req,
    input wire csr_we,
    input wire [11:0] csr_addr,
    input wire [31:0] csr_wdata,
    input wire [1:0] csr_priv,
    output reg csr_valid,
    output reg [31:0] csr_rdata,
    output reg csr_illegal,
    // float unit flag accrual
    input wire [4:0] fpu_flags_set,
    input wire fpu_flags_we,
    // identity
    input wire [31:0] thread_identifier_input,
    // loop state to the fetch logic, and the stored rounding mode
    output reg [31:0] loop0_start_address,
    output reg [31:0] loop0_end_address,
    output reg [31:0] loop0_iteration_count,
    output reg [31:0] loop1_start_address,
    output reg [31:0] loop1_end_address,
    output reg [31:0] loop1_iteration_count,
    output reg [2:0] fp_rounding_mode
);

    localparam [0:0] has_fpu = (float_unit_present == 1) ? 1'b1 : 1'b0;
    localparam [0:0] has_ext = (custom_extension_enable == 1) ? 1'b1 : 1'b0;

    reg [4:0] fp_flags;
    reg hit;
    reg read_only;
    reg [31:0] rd;
    wire [1:0] priv_level;
    wire take;

    // machine mode only; every listed level is user so any level qualifies
    assign priv_level = `FPLC_PRIV_MACHINE; // [R14]

    always @* begin
        hit = 1'b0;
        read_only = 1'b0;
        rd = 32'h00000000;
        case (csr_addr)
            `FPLC_ADDR_FLAGS: begin
                hit = has_fpu; // [R4]
                rd = {27'h0000000, fp_flags}; // [R5]
            end
            `FPLC_ADDR_ROUND: begin
                hit = has_fpu; // [R6]
                rd = {29'h00000000, fp_rounding_mode};
            end
            `FPLC_ADDR_FCSR: begin
                hit = has_fpu;
                rd = {24'h000000, fp_rounding_mode, fp_flags}; // [R8] [R9]
            end
            `FPLC_ADDR_LP0_START: begin
                hit = has_ext; // [R10]
                rd = loop0_start_address;
            end
            `FPLC_ADDR_LP0_END: begin
                hit = has_ext; // [R11]
                rd = loop0_end_address;
            end
            `FPLC_ADDR_LP0_COUNT: begin
                hit = has_ext; // [R12]
                rd = loop0_iteration_count;
            end
            `FPLC_ADDR_LP1_START: begin
                hit = has_ext; // [R10]
                rd = loop1_start_address;
            end
            `FPLC_ADDR_LP1_END: begin
                hit = has_ext; // [R11]
                rd = loop1_end_address;
            end
            `FPLC_ADDR_LP1_COUNT: begin
                hit = has_ext; // [R12]
                rd = loop1_iteration_count;
            end
            `FPLC_ADDR_THREAD_ID: begin
                hit = has_ext;
                read_only = 1'b1;
                rd = thread_identifier_input; // [R15]
            end
            `FPLC_ADDR_PRIV: begin
                hit = has_ext;
                read_only = 1'b1;
                rd = {30'h00000000, priv_level}; // [R13] [R14]
            end
            default: begin
                hit = 1'b0; // [R17]
            end
        endcase
    end

    // csr_priv is any level at or above user, which all these registers list
    assign take = csr_req & csr_we & hit & ~read_only; // [R1] [R3]

    always @(posedge mclk) begin
        if (srst) begin
            fp_flags <= `FPLC_FLAGS_RESET;
            fp_rounding_mode <= `FPLC_ROUND_RESET;
            loop0_start_address <= `FPLC_LOOP_RESET;
            loop0_end_address <= `FPLC_LOOP_RESET;
            loop0_iteration_count <= `FPLC_LOOP_RESET;
            loop1_start_address <= `FPLC_LOOP_RESET;
            loop1_end_address <= `FPLC_LOOP_RESET;
            loop1_iteration_count <= `FPLC_LOOP_RESET;
            csr_valid <= 1'b0;
            csr_rdata <= 32'h00000000;
            csr_illegal <= 1'b0;
        end else begin
            csr_valid <= csr_req;
            csr_rdata <= (csr_req & hit) ? rd : 32'h00000000;
            csr_illegal <= csr_req & (~hit | (csr_we & read_only)); // [R16] [R17]
            // flags accrue from the float unit; a csr write replaces them, then accrual ors in
            if (take && (csr_addr == `FPLC_ADDR_FLAGS)) begin
                fp_flags <= csr_wdata[4:0] | (fpu_flags_we ? fpu_flags_set : 5'h00); // [R2] [R5]
            end else if (take && (csr_addr == `FPLC_ADDR_FCSR)) begin
                fp_flags <= csr_wdata[4:0] | (fpu_flags_we ? fpu_flags_set : 5'h00); // [R9]
            end else if (fpu_flags_we && has_fpu) begin
                fp_flags <= fp_flags | fpu_flags_set;
            end
            // all eight codes are stored; 101 and 110 are left for the float unit to reject
            if (take && (csr_addr == `FPLC_ADDR_ROUND)) begin
                fp_rounding_mode <= csr_wdata[2:0]; // [R7]
            end else if (take && (csr_addr == `FPLC_ADDR_FCSR)) begin
                fp_rounding_mode <= csr_wdata[`FPLC_FCSR_ROUND_MSB:`FPLC_FCSR_ROUND_LSB]; // [R9]
            end
            if (take && (csr_addr == `FPLC_ADDR_LP0_START)) begin
                loop0_start_address <= csr_wdata; // [R2]
            end
            if (take && (csr_addr == `FPLC_ADDR_LP0_END)) begin
                loop0_end_address <= csr_wdata;
            end
            if (take && (csr_addr == `FPLC_ADDR_LP0_COUNT)) begin
                loop0_iteration_count <= csr_wdata;
            end
            if (take && (csr_addr == `FPLC_ADDR_LP1_START)) begin
                loop1_start_address <= csr_wdata;
            end
            if (take && (csr_addr == `FPLC_ADDR_LP1_END)) begin
                loop1_end_address <= csr_wdata;
            end
            if (take && (csr_addr == `FPLC_ADDR_LP1_COUNT)) begin
                loop1_iteration_count <= csr_wdata;
            end
        end
    end

endmodule // fplc_csr_bank

// ### fplc_consts.vh
// constants for the float and loop csr bank
// Function
// [R1] read-only fields ignore csr writes and return a constant or a core-produced value.
// [R2] read/write fields hold the written value until rewritten or updated by the core.
// [R3] field access behaviour applies at the listed privilege level or any higher level.
// [R4] the exception-flag register at 0x001 exists only with the float unit and resets to zero.
// [R5] exception-flag bits 31:5 read zero; bits 4..0 are invalid, div-zero, overflow, underflow, inexact.
// [R6] the rounding register at 0x002 exists only with the float unit, resets to zero, bits 31:3 read zero.
// [R7] rounding codes: 000 even, 001 zero, 010 down, 011 up, 100 max-magnitude, 111 dynamic; 101/110 invalid.
// [R8] combined status at 0x003 resets to zero, bits 7:5 rounding, 4:0 flags, upper bits zero.
// [R9] combined status and the flag and rounding registers share one storage.
// [R10] two 32-bit loop-start registers at 0x800 and 0x804 exist with the extension, reset zero.
// [R11] two 32-bit loop-end registers at 0x801 and 0x805 exist with the extension, reset zero.
// [R12] two 32-bit loop-count registers at 0x802 and 0x806 exist with the extension, reset zero.
// [R13] a read-only privilege register at 0xcc1 exists with the extension, bits 31:2 read zero.
// [R14] privilege encodes 11 machine, 10 hyper, 01 super, 00 user, and always reads 11.
// [R15] a read-only thread-identity register at 0xcc0 returns the thread identifier input.
// [R16] a write to a read-only register raises an illegal-instruction exception.
// [R17] any access to an unimplemented address raises an illegal-instruction exception.
`ifndef FPLC_CONSTS_VH
`define FPLC_CONSTS_VH
`define FPLC_ADDR_FLAGS 12'h001
`define FPLC_ADDR_ROUND 12'h002
`define FPLC_ADDR_FCSR 12'h003
`define FPLC_ADDR_LP0_START 12'h800
`define FPLC_ADDR_LP0_END 12'h801
`define FPLC_ADDR_LP0_COUNT 12'h802
`define FPLC_ADDR_LP1_START 12'h804
`define FPLC_ADDR_LP1_END 12'h805
`define FPLC_ADDR_LP1_COUNT 12'h806
`define FPLC_ADDR_THREAD_ID 12'hcc0
`define FPLC_ADDR_PRIV 12'hcc1
`define FPLC_FLAGS_RESET 5'h00
`define FPLC_ROUND_RESET 3'h0
`define FPLC_LOOP_RESET 32'h00000000
`define FPLC_PRIV_MACHINE 2'h3
`define FPLC_PRIV_HYPER 2'h2
`define FPLC_PRIV_SUPER 2'h1
`define FPLC_PRIV_USER 2'h0
`define FPLC_ROUND_NEAREST_EVEN 3'h0
`define FPLC_ROUND_TOWARD_ZERO 3'h1
`define FPLC_ROUND_DOWN 3'h2
`define FPLC_ROUND_UP 3'h3
`define FPLC_ROUND_NEAREST_MAX_MAGNITUDE 3'h4
`define FPLC_ROUND_DYNAMIC 3'h7
`define FPLC_FCSR_ROUND_MSB 7
`define FPLC_FCSR_ROUND_LSB 5
`define FPLC_FLAG_INVALID 4
`define FPLC_FLAG_DIV_ZERO 3
`define FPLC_FLAG_OVERFLOW 2
`define FPLC_FLAG_UNDERFLOW 1
`define FPLC_FLAG_INEXACT 0
`endif

// ### fplc_csr_bank_checker.sv
// assertion checker for the float and loop csr bank
module fplc_csr_bank_checker #(
    parameter float_unit_present = 1,
    parameter custom_extension_enable = 1
) (
    // clock, reset and access
    input wire mclk,
    input wire srst,
    input wire csr_req,
    input wire csr_we,
    input wire [11:0] csr_addr,
    input wire [31:0] csr_wdata,
    input wire [31:0] csr_rdata,
    input wire csr_illegal,
    // identity and stored state
    input wire [31:0] thread_identifier_input,
    input wire [31:0] loop0_start_address,
    input wire [2:0] fp_rounding_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [31:0] wd_q;
    wire fp = float_unit_present == 1 && csr_addr inside {[12'h001:12'h003]};
    wire ext = custom_extension_enable == 1 && csr_addr inside {12'h800, 12'h801, 12'h802,
        12'h804, 12'h805, 12'h806, 12'hcc0, 12'hcc1};
    wire wr = csr_req && csr_we;
    // write data is scrambled once released, so keep the taken copy
    always @(posedge mclk) wd_q <= csr_wdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_unmapped_trap: assert property (csr_req && !fp && !ext |=> csr_illegal && csr_rdata == 0)
        else $error("unmapped not trapped");
    a_legal_read_ok: assert property (csr_req && !csr_we && (fp || ext) |=> !csr_illegal)
        else $error("legal read trapped");
    a_ro_write_trap: assert property (wr && ext && csr_addr[11:1] == 11'h660 |=> csr_illegal)
        else $error("ro write not trapped");
    a_priv_machine: assert property (csr_req && ext && csr_addr == 12'hcc1 |=> csr_rdata == 3)
        else $error("privilege wrong");
    a_thread_id: assert property (csr_req && ext && csr_addr == 12'hcc0
        |=> csr_rdata == $past(thread_identifier_input)) else $error("thread id wrong");
    a_round_store: assert property (wr && fp && csr_addr == 12'h002 |=> fp_rounding_mode == wd_q[2:0])
        else $error("rounding not stored");
    a_loop_store: assert property (wr && ext && csr_addr == 12'h800 |=> loop0_start_address == wd_q)
        else $error("loop start not stored");
    a_fcsr_upper: assert property (csr_req && fp && csr_addr == 12'h003 |=> csr_rdata[31:8] == 0)
        else $error("fcsr upper bits set");
endmodule // fplc_csr_bank_checker
bind fplc_csr_bank fplc_csr_bank_checker #(.float_unit_present(float_unit_present),
    .custom_extension_enable(custom_extension_enable)) u_fplc_csr_bank_checker (.mclk(mclk),
    .srst(srst), .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .fp_rounding_mode(fp_rounding_mode),
    .thread_identifier_input(thread_identifier_input), .loop0_start_address(loop0_start_address));

// ### fplc_pipe_model.sv
// pipeline model issuing csr accesses to the bank
module fplc_pipe_model (
    // clock
    input wire logic mclk,
    // csr access
    output logic csr_req,
    output logic csr_we,
    output logic [11:0] csr_addr,
    output logic [31:0] csr_wdata,
    input wire logic csr_valid,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_illegal
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {csr_req, csr_we, csr_addr, csr_wdata} = '0;
    task access(input logic we, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic ill);
        @(negedge mclk);
        {csr_req, csr_we, csr_addr, csr_wdata} = {1'b1, we, a, d};
        @(negedge mclk);
        // answer stands for the one cycle after the taking edge, so take it here
        q = csr_valid ? csr_rdata : 'x;
        ill = csr_valid ? csr_illegal : 1'bx;
        // released address and data lines carry inverted values; csr_we keeps the last value
        {csr_req, csr_addr, csr_wdata} = {1'b0, ~a, ~d};
    endtask
endmodule // fplc_pipe_model

// ### test_fplc_csr_bank.sv
// self-checking bench for the float and loop csr bank
module test_fplc_csr_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, srst = 1, csr_req, csr_we, csr_valid, csr_illegal, il, fpu_flags_we = 0;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, csr_rdata, rd, lo[6];
    logic [4:0] fpu_flags_set = 5'h00;
    logic [2:0] fp_rounding_mode;
    logic [11:0] am[9] = '{12'h800, 12'h801, 12'h802, 12'h804, 12'h805, 12'h806, 12'h004, 12'h803, 12'hcc2};
    int mismatches = 0, samples_checked = 0, cycles = 0, i;
    fplc_csr_bank u_fplc_csr_bank (.mclk(mclk), .srst(srst), .csr_req(csr_req), .csr_we(csr_we),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_priv(2'h0), .csr_valid(csr_valid),
        .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .fpu_flags_set(fpu_flags_set),
        .fpu_flags_we(fpu_flags_we), .thread_identifier_input(32'h5a5a0001),
        .loop0_start_address(lo[0]), .loop0_end_address(lo[1]), .loop0_iteration_count(lo[2]),
        .loop1_start_address(lo[3]), .loop1_end_address(lo[4]), .loop1_iteration_count(lo[5]),
        .fp_rounding_mode(fp_rounding_mode));
    fplc_pipe_model u_fplc_pipe_model (.mclk(mclk), .csr_req(csr_req), .csr_we(csr_we),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_valid(csr_valid),
        .csr_rdata(csr_rdata), .csr_illegal(csr_illegal));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) if (++cycles == 1000) begin
        mismatches++;
        test_done();
    end
    task chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task acc(input logic we, input logic [11:0] a, input logic [31:0] d);
        u_fplc_pipe_model.access(we, a, d, rd, il);
    endtask
    task t_reset;
        for (i = 0; i < 6; i++) begin
            acc(0, am[i], 0);
            chk("loop reset", 0, rd);
        end
        for (i = 1; i < 4; i++) begin
            acc(0, i[11:0], 0);
            chk("float reset", 0, rd);
        end
        acc(1, 12'hcc1, 0);
        chk("privilege", 3, rd);
        chk("ro write trap", 1, il);
        acc(1, 12'hcc0, 0);
        chk("thread id", 32'h5a5a0001, rd);
        chk("ro write trap", 1, il);
        $display("reset and read-only test done");
    endtask
    task t_fp;
        acc(1, 12'h003, 32'hffffffe5);
        acc(0, 12'h001, 0);
        chk("flags view", 5, rd);
        for (i = 0; i < 8; i++) begin
            acc(1, 12'h002, 32'hfffffff8 | i);
            acc(0, 12'h003, 0);
            chk("combined", {24'h0, i[2:0], 5'h05}, rd);
        end
        chk("rounding out", 7, {29'h0, fp_rounding_mode});
        acc(1, 12'h001, 0);
        {fpu_flags_we, fpu_flags_set} = 6'h32;
        @(negedge mclk) fpu_flags_we = 0;
        acc(0, 12'h001, 0);
        chk("accrued flags", 32'h12, rd);
        $display("float status test done");
    endtask
    task t_loops;
        for (i = 0; i < 6; i++) acc(1, am[i], 32'h13570000 + i);
        for (i = 0; i < 9; i++) begin
            acc(i < 6 ? 0 : 1, am[i], 32'hffffffff);
            chk("trap", i > 5, il);
            chk("read data", i < 6 ? 32'h13570000 + i : 0, rd);
            if (i < 6) chk("loop out", 32'h13570000 + i, lo[i]);
        end
        $display("loop and unmapped test done");
    endtask
    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        srst = 0;
        t_reset();
        t_fp();
        t_loops();
        test_done();
    end
endmodule // test_fplc_csr_bank
